/* File: dv/larc_tb.sv */
// Self-checking testbench for the lane align and resync control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import larc_pkg::*;
   typedef struct packed {
      logic [17:0] idx;
      logic [7:0]  d;
      logic [2:0]  sel;
      logic [15:0] exp;
   } larc_row_t;
   // ------------------------------------------------------------
   // Ordinary cases: write, settle, compare levels, read back
   // ------------------------------------------------------------
   localparam larc_row_t ROWS [14] = '{
      '{LARC_IDX_RALG_A, 8'ha0, 3'd0, 16'h000a}, '{LARC_IDX_RALG_B, 8'h50, 3'd0, 16'h005a},
      '{LARC_IDX_GRP_A, 8'he4, 3'd1, 16'h00d8}, '{LARC_IDX_GRP_B, 8'h1b, 3'd1, 16'h27d8},
      '{LARC_IDX_LSM_A, 8'h05, 3'd2, 16'h0005}, '{LARC_IDX_RSYN_A, 8'h80, 3'd2, 16'h000f},
      '{LARC_IDX_RSYN_B, 8'h80, 3'd2, 16'h00ff}, '{LARC_IDX_RSYN_A, 8'h00, 3'd2, 16'h00f5},
      '{LARC_IDX_BYP_A, 8'h01, 3'd3, 16'h0001}, '{LARC_IDX_BYP_B, 8'h01, 3'd3, 16'h0003},
      '{LARC_IDX_CHZ, 8'h90, 3'd4, 16'h0022}, '{LARC_IDX_CHZ, 8'h60, 3'd4, 16'h0014},
      '{LARC_IDX_CHZ, 8'hf0, 3'd4, 16'h0038}, '{LARC_IDX_CHZ, 8'h00, 3'd4, 16'h0001}};
   // Action writes: exp holds {ptr_reset lanes, realign lanes}
   localparam larc_row_t ACTS [10] = '{
      '{LARC_IDX_RALG_A, 8'h09, 3'd0, 16'h0009}, '{LARC_IDX_RALG_A, 8'h09, 3'd0, 16'h0000},
      '{LARC_IDX_RALG_A, 8'h00, 3'd0, 16'h0000}, '{LARC_IDX_RALG_A, 8'h08, 3'd0, 16'h0008},
      '{LARC_IDX_RSYN_A, 8'h02, 3'd0, 16'h0200}, '{LARC_IDX_RSYN_A, 8'h10, 3'd0, 16'h0300},
      '{LARC_IDX_RSYN_A, 8'h20, 3'd0, 16'h0c00}, '{LARC_IDX_RSYN_A, 8'h40, 3'd0, 16'h0f00},
      '{LARC_IDX_RSYN_B, 8'h21, 3'd0, 16'hd000}, '{LARC_IDX_RALG_B, 8'h06, 3'd0, 16'h0060}};
   localparam logic [17:0] RO [11] = '{LARC_IDX_STAT_A, LARC_IDX_RALG_A, LARC_IDX_GRP_A,
      LARC_IDX_RSYN_A, LARC_IDX_BYP_A, LARC_IDX_STAT_B, LARC_IDX_RALG_B, LARC_IDX_GRP_B,
      LARC_IDX_RSYN_B, LARC_IDX_BYP_B, LARC_IDX_CHZ};
   logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic                  charz_enable, charz_direction;
   logic [LARC_AW-1:0]    paddr;
   logic [31:0]           pwdata, prdata, rd;
   larc_lane_stat_t [7:0] lane_stat;
   larc_lane_ctrl_t [7:0] lane_ctrl;
   logic [1:0]            oos, deskew_bypass;
   logic [3:0]            charz_lane_onehot;
   logic [15:0]           seen;
   int                    errors, cmp_count, tot;
   larc_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lane_stat(lane_stat), .quad_group_out_of_sync(oos), .lane_ctrl(lane_ctrl),
      .deskew_bypass(deskew_bypass), .charz_enable(charz_enable),
      .charz_direction(charz_direction), .charz_lane_onehot(charz_lane_onehot), .irq(irq));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude();
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_irq(input logic [17:0] idx, input logic [31:0] d, input logic e);
      apb(1'b1, idx, d);
      repeat (3) @(posedge pclk);
      check(irq, e);
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic chk_reset();
      foreach (RO[i]) begin
         apb(1'b0, RO[i], 32'h0);
         check(rd, 64'h0);
      end
      check({lane_ctrl, deskew_bypass, irq}, 64'h0);
   endtask
   // Levels seen on outputs, grouped as the table rows select
   function automatic logic [15:0] obs(input logic [2:0] s);
      logic [15:0] v;
      v = '0;
      for (int l = 0; l < 8; l++) begin
         if (s == 3'd0) v[l] = lane_ctrl[l].participate;
         if (s == 3'd1) v[2*l +: 2] = lane_ctrl[l].group;
         if (s == 3'd2) v[l] = lane_ctrl[l].use_xaui;
      end
      if (s == 3'd3) v[1:0] = deskew_bypass;
      if (s == 3'd4) v[5:0] = {charz_enable, charz_direction, charz_lane_onehot};
      return v;
   endfunction
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lane_stat, oos} = '0;
      do_reset();
      chk_reset();
      foreach (ROWS[i]) begin
         apb(1'b1, ROWS[i].idx, {24'h0, ROWS[i].d});
         repeat (3) @(posedge pclk);
         check(obs(ROWS[i].sel), ROWS[i].exp);
         apb(1'b0, ROWS[i].idx, 32'h0);
         check({err, rd}, {1'b0, 24'h0, ROWS[i].d});
      end
      foreach (ACTS[i]) begin
         apb(1'b1, ACTS[i].idx, {24'h0, ACTS[i].d});
         seen = '0;
         tot = 0;
         repeat (6) begin
            @(posedge pclk);
            for (int l = 0; l < 8; l++) begin
               seen[l] = seen[l] | lane_ctrl[l].realign;
               seen[8+l] = seen[8+l] | lane_ctrl[l].ptr_reset;
               tot += int'(lane_ctrl[l].realign) + int'(lane_ctrl[l].ptr_reset);
            end
         end
         check({tot, seen}, {$countones(ACTS[i].exp), ACTS[i].exp});
      end
      lane_stat[0] <= 3'b100;
      lane_stat[1] <= 3'b011;
      lane_stat[2] <= 3'b010;
      lane_stat[5] <= 3'b100;
      repeat (8) @(posedge pclk);
      apb(1'b0, LARC_IDX_STAT_A, 32'h0);
      check(rd, 64'h09);
      apb(1'b0, LARC_IDX_STAT_B, 32'h0);
      check(rd, 64'h04);
      apb(1'b1, LARC_IDX_STAT_A, 32'hff);
      check(err, 64'h1);
      apb(1'b0, LARC_IDX_STAT_A, 32'h0);
      check(rd, 64'h09);
      apb(1'b0, 18'h30805, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      oos <= 2'b01;
      repeat (6) @(posedge pclk);
      apb(1'b0, LARC_IDX_IRQ_STAT, 32'h0);
      check({irq, rd}, {1'b0, 32'h001});
      wr_irq(LARC_IDX_IRQ_MASK, 32'h001, 1'b1);
      wr_irq(LARC_IDX_IRQ_STAT, 32'h001, 1'b0);
      lane_stat[0] <= 3'b000;
      oos <= 2'b11;
      repeat (6) @(posedge pclk);
      apb(1'b0, LARC_IDX_IRQ_STAT, 32'h0);
      check({irq, rd}, {1'b0, 32'h006});
      wr_irq(LARC_IDX_IRQ_MASK, 32'h006, 1'b1);
      wr_irq(LARC_IDX_IRQ_STAT, 32'h006, 1'b0);
      lane_stat <= '0;
      oos <= 2'b00;
      do_reset();
      chk_reset();
      conclude();
   end
endmodule

/* File: rtl/larc_pkg.sv */
// Package: register map, field layout, types for lane align/resync control
package larc_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam int          LARC_AW            = 20;
   localparam int          LARC_IW            = 18;
   localparam logic [17:0] LARC_IDX_STAT_A    = 18'h30804;
   localparam logic [17:0] LARC_IDX_RALG_A    = 18'h30810;
   localparam logic [17:0] LARC_IDX_GRP_A     = 18'h30811;
   localparam logic [17:0] LARC_IDX_RSYN_A    = 18'h30820;
   localparam logic [17:0] LARC_IDX_BYP_A     = 18'h30821;
   localparam logic [17:0] LARC_IDX_LSM_A     = 18'h30822;
   localparam logic [17:0] LARC_IDX_STAT_B    = 18'h30904;
   localparam logic [17:0] LARC_IDX_RALG_B    = 18'h30910;
   localparam logic [17:0] LARC_IDX_GRP_B     = 18'h30911;
   localparam logic [17:0] LARC_IDX_RSYN_B    = 18'h30920;
   localparam logic [17:0] LARC_IDX_BYP_B     = 18'h30921;
   localparam logic [17:0] LARC_IDX_LSM_B     = 18'h30922;
   localparam logic [17:0] LARC_IDX_CHZ       = 18'h30933;
   localparam logic [17:0] LARC_IDX_IRQ_STAT  = 18'h30a10;
   localparam logic [17:0] LARC_IDX_IRQ_MASK  = 18'h30a11;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          LARC_PART_LSB      = 4;
   localparam int          LARC_PAIR_LSB      = 4;
   localparam int          LARC_QUAD_BIT      = 6;
   localparam int          LARC_XSEL_BIT      = 7;
   localparam int          LARC_BYP_BIT       = 0;
   localparam int          LARC_CHZ_SEL_LSB   = 4;
   localparam int          LARC_CHZ_DIR_BIT   = 6;
   localparam int          LARC_CHZ_EN_BIT    = 7;
   localparam int          LARC_IRQ_W         = 10;
   localparam int          LARC_IRQ_OOS_LSB   = 0;
   localparam int          LARC_IRQ_LOST_LSB  = 2;
   localparam logic [7:0]  LARC_RST_BYTE      = 8'h00;
   localparam logic [9:0]  LARC_RST_IRQ       = 10'h000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LARC_LS_NOSYNC = 2'b00,
      LARC_LS_NOCOMMA_CV = 2'b01,
      LARC_LS_DONE   = 2'b10,
      LARC_LS_UNUSED = 2'b11
   } larc_link_stat_t;

   typedef enum logic [1:0] {
      LARC_GRP_NONE  = 2'b00,
      LARC_GRP_FOUR  = 2'b01,
      LARC_GRP_TWO   = 2'b10,
      LARC_GRP_EIGHT = 2'b11
   } larc_grp_t;

   typedef enum logic [3:0] {
      LARC_R_NONE    = 4'b0000,
      LARC_R_STAT    = 4'b0001,
      LARC_R_RALG    = 4'b0010,
      LARC_R_GRP     = 4'b0011,
      LARC_R_RSYN    = 4'b0100,
      LARC_R_BYP     = 4'b0101,
      LARC_R_LSM     = 4'b0110,
      LARC_R_CHZ     = 4'b0111,
      LARC_R_IRQS    = 4'b1000,
      LARC_R_IRQM    = 4'b1001
   } larc_reg_t;

   typedef struct packed {
      larc_reg_t id;
      logic      quad;
   } larc_dec_t;

   typedef struct packed {
      logic      realign;
      logic      participate;
      larc_grp_t group;
      logic      ptr_reset;
      logic      use_xaui;
   } larc_lane_ctrl_t;

   typedef struct packed {
      logic sync_done;
      logic no_comma;
      logic code_violation;
   } larc_lane_stat_t;

endpackage

/* File: rtl/larc_top.sv */
// Lane realign, alignment, resync and link select control with APB registers
module larc_top (
   input  wire logic                               pclk,
   input  wire logic                               presetn,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [larc_pkg::LARC_AW-1:0]       paddr,
   input  wire logic [31:0]                        pwdata,
   output logic      [31:0]                        prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   input  wire larc_pkg::larc_lane_stat_t [7:0]    lane_stat,
   input  wire logic [1:0]                         quad_group_out_of_sync,
   output larc_pkg::larc_lane_ctrl_t [7:0]         lane_ctrl,
   output logic [1:0]                              deskew_bypass,
   output logic                                    charz_enable,
   output logic                                    charz_direction,
   output logic [3:0]                              charz_lane_onehot,
   output logic                                    irq
);
   import larc_pkg::*;

   // ------------------------------------------------------------
   // Address decoding
   // ------------------------------------------------------------
   function automatic larc_dec_t dec_addr(input logic [LARC_AW-1:0] a);
      larc_dec_t d;
      logic [LARC_IW-1:0] ix;
      d = '{id: LARC_R_NONE, quad: 1'b0};
      ix = a[LARC_AW-1:2];
      if (a[1:0] != 2'b00) begin
         d.id = LARC_R_NONE;
      end else if (ix == LARC_IDX_STAT_A || ix == LARC_IDX_STAT_B) begin
         d.id = LARC_R_STAT;
      end else if (ix == LARC_IDX_RALG_A || ix == LARC_IDX_RALG_B) begin
         d.id = LARC_R_RALG;
      end else if (ix == LARC_IDX_GRP_A || ix == LARC_IDX_GRP_B) begin
         d.id = LARC_R_GRP;
      end else if (ix == LARC_IDX_RSYN_A || ix == LARC_IDX_RSYN_B) begin
         d.id = LARC_R_RSYN;
      end else if (ix == LARC_IDX_BYP_A || ix == LARC_IDX_BYP_B) begin
         d.id = LARC_R_BYP;
      end else if (ix == LARC_IDX_LSM_A || ix == LARC_IDX_LSM_B) begin
         d.id = LARC_R_LSM;
      end else if (ix == LARC_IDX_CHZ) begin
         d.id = LARC_R_CHZ;
      end else if (ix == LARC_IDX_IRQ_STAT) begin
         d.id = LARC_R_IRQS;
      end else if (ix == LARC_IDX_IRQ_MASK) begin
         d.id = LARC_R_IRQM;
      end
      // Quad B registers live in the 0x309xx page
      d.quad = (ix[11:8] == 4'h9);
      return d;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]            ralg_r      [2];
   logic [7:0]            grp_r       [2];
   logic [7:0]            rsyn_r      [2];
   logic                  byp_r       [2];
   logic [3:0]            lsm_r       [2];
   logic [3:0]            ralg_prev_r [2];
   logic [6:0]            rsyn_prev_r [2];
   logic [3:0]            chz_r;
   logic [LARC_IRQ_W-1:0] irq_stat_r;
   logic [LARC_IRQ_W-1:0] irq_mask_r;
   logic [LARC_IRQ_W-1:0] irq_set;
   logic [7:0]            stat_meta_r [3];
   logic [7:0]            stat_sync_r [3];
   logic [1:0]            oos_meta_r;
   logic [1:0]            oos_sync_r;
   logic [1:0]            oos_prev_r;
   logic [7:0]            done_prev_r;
   logic                  cv_seen_r   [8];
   larc_link_stat_t       link_stat_r [8];
   larc_lane_ctrl_t       lane_ctrl_r [8];
   logic [31:0]           prdata_r;
   logic                  pready_r;
   logic                  pslverr_r;
   logic                  irq_r;
   logic [1:0]            byp_out_r;
   logic                  chz_en_r;
   logic                  chz_dir_r;
   logic [3:0]            chz_oh_r;
   larc_dec_t             dec;
   logic                  wr_en;
   logic                  setup;
   logic [31:0]           rd_data;
   logic [7:0]            stat_byte   [2];

   assign dec   = dec_addr(paddr);
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready_r & (dec.id != LARC_R_NONE);

   // ------------------------------------------------------------
   // APB slave: answer registered at setup, taken in first access
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      if (dec.id == LARC_R_STAT) begin
         rd_data[7:0] = stat_byte[dec.quad];
      end else if (dec.id == LARC_R_RALG) begin
         rd_data[7:0] = ralg_r[dec.quad];
      end else if (dec.id == LARC_R_GRP) begin
         rd_data[7:0] = grp_r[dec.quad];
      end else if (dec.id == LARC_R_RSYN) begin
         rd_data[7:0] = rsyn_r[dec.quad];
      end else if (dec.id == LARC_R_BYP) begin
         rd_data[LARC_BYP_BIT] = byp_r[dec.quad];
      end else if (dec.id == LARC_R_LSM) begin
         rd_data[3:0] = lsm_r[dec.quad];
      end else if (dec.id == LARC_R_CHZ) begin
         rd_data[7:4] = chz_r;
      end else if (dec.id == LARC_R_IRQS) begin
         rd_data[LARC_IRQ_W-1:0] = irq_stat_r;
      end else if (dec.id == LARC_R_IRQM) begin
         rd_data[LARC_IRQ_W-1:0] = irq_mask_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
         pready_r  <= 1'b1;
         pslverr_r <= (dec.id == LARC_R_NONE) | (pwrite & (dec.id == LARC_R_STAT));
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Software control registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int q = 0; q < 2; q++) begin
            ralg_r[q] <= LARC_RST_BYTE;
            grp_r[q]  <= LARC_RST_BYTE;
            rsyn_r[q] <= LARC_RST_BYTE;
            byp_r[q]  <= 1'b0;
            lsm_r[q]  <= 4'h0;
         end
         chz_r      <= 4'h0;
         irq_mask_r <= LARC_RST_IRQ;
      end else if (wr_en) begin
         if (dec.id == LARC_R_RALG) begin
            ralg_r[dec.quad] <= pwdata[7:0];
         end else if (dec.id == LARC_R_GRP) begin
            grp_r[dec.quad] <= pwdata[7:0];
         end else if (dec.id == LARC_R_RSYN) begin
            rsyn_r[dec.quad] <= pwdata[7:0];
         end else if (dec.id == LARC_R_BYP) begin
            byp_r[dec.quad] <= pwdata[LARC_BYP_BIT];
         end else if (dec.id == LARC_R_LSM) begin
            lsm_r[dec.quad] <= pwdata[3:0];
         end else if (dec.id == LARC_R_CHZ) begin
            chz_r <= pwdata[7:4];
         end else if (dec.id == LARC_R_IRQM) begin
            irq_mask_r <= pwdata[LARC_IRQ_W-1:0];
         end
      end
   end

   // Previous copies for zero-to-one detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int q = 0; q < 2; q++) begin
            ralg_prev_r[q] <= 4'h0;
            rsyn_prev_r[q] <= 7'h00;
         end
      end else begin
         for (int q = 0; q < 2; q++) begin
            ralg_prev_r[q] <= ralg_r[q][3:0];
            rsyn_prev_r[q] <= rsyn_r[q][6:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Status input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 3; k++) begin
            stat_meta_r[k] <= 8'h00;
            stat_sync_r[k] <= 8'h00;
         end
         oos_meta_r <= 2'b00;
         oos_sync_r <= 2'b00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            stat_meta_r[0][i] <= lane_stat[i].sync_done;
            stat_meta_r[1][i] <= lane_stat[i].no_comma;
            stat_meta_r[2][i] <= lane_stat[i].code_violation;
         end
         for (int k = 0; k < 3; k++) begin
            stat_sync_r[k] <= stat_meta_r[k];
         end
         oos_meta_r <= quad_group_out_of_sync;
         oos_sync_r <= oos_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Per-lane control and link status
   // ------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_lane
      localparam int Q = i / 4;
      localparam int L = i % 4;
      logic rise_single;
      logic rise_pair;
      logic rise_quad;

      assign rise_single = rsyn_r[Q][L] & ~rsyn_prev_r[Q][L];
      assign rise_pair   = rsyn_r[Q][LARC_PAIR_LSB + L/2]
                           & ~rsyn_prev_r[Q][LARC_PAIR_LSB + L/2];
      assign rise_quad   = rsyn_r[Q][LARC_QUAD_BIT] & ~rsyn_prev_r[Q][LARC_QUAD_BIT];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lane_ctrl_r[i] <= '{realign: 1'b0, participate: 1'b0, group: LARC_GRP_NONE,
                               ptr_reset: 1'b0, use_xaui: 1'b0};
         end else begin
            lane_ctrl_r[i].realign     <= ralg_r[Q][L] & ~ralg_prev_r[Q][L];
            lane_ctrl_r[i].participate <= ralg_r[Q][LARC_PART_LSB + L];
            lane_ctrl_r[i].group       <= larc_grp_t'({grp_r[Q][2*L], grp_r[Q][2*L+1]});
            lane_ctrl_r[i].ptr_reset   <= rise_single | rise_pair | rise_quad;
            lane_ctrl_r[i].use_xaui    <= rsyn_r[Q][LARC_XSEL_BIT] | lsm_r[Q][L];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cv_seen_r[i]   <= 1'b0;
            link_stat_r[i] <= LARC_LS_NOSYNC;
         end else begin
            if (!stat_sync_r[1][i]) begin
               cv_seen_r[i] <= 1'b0;
            end else if (stat_sync_r[2][i]) begin
               cv_seen_r[i] <= 1'b1;
            end
            if (stat_sync_r[0][i]) begin
               link_stat_r[i] <= LARC_LS_DONE;
            end else if (stat_sync_r[1][i] && (cv_seen_r[i] || stat_sync_r[2][i])) begin
               link_stat_r[i] <= LARC_LS_NOCOMMA_CV;
            end else begin
               link_stat_r[i] <= LARC_LS_NOSYNC;
            end
         end
      end

      assign stat_byte[Q][2*L]   = link_stat_r[i][1];
      assign stat_byte[Q][2*L+1] = link_stat_r[i][0];
      assign lane_ctrl[i]        = lane_ctrl_r[i];
      assign irq_set[LARC_IRQ_LOST_LSB + i] = done_prev_r[i] & ~stat_sync_r[0][i];
   end

   // ------------------------------------------------------------
   // Quad and characterization outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byp_out_r <= 2'b00;
         chz_en_r  <= 1'b0;
         chz_dir_r <= 1'b0;
         chz_oh_r  <= 4'h0;
      end else begin
         byp_out_r <= {byp_r[1], byp_r[0]};
         chz_en_r  <= chz_r[LARC_CHZ_EN_BIT - 4];
         chz_dir_r <= chz_r[LARC_CHZ_DIR_BIT - 4];
         chz_oh_r  <= 4'h1 << {chz_r[LARC_CHZ_SEL_LSB - 3], chz_r[LARC_CHZ_SEL_LSB - 4]};
      end
   end

   // ------------------------------------------------------------
   // Interrupts: sticky events, write one to clear, set wins
   // ------------------------------------------------------------
   assign irq_set[LARC_IRQ_OOS_LSB +: 2] = oos_sync_r & ~oos_prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oos_prev_r  <= 2'b00;
         done_prev_r <= 8'h00;
         irq_stat_r  <= LARC_RST_IRQ;
         irq_r       <= 1'b0;
      end else begin
         oos_prev_r  <= oos_sync_r;
         done_prev_r <= stat_sync_r[0];
         if (wr_en && dec.id == LARC_R_IRQS) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[LARC_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign deskew_bypass     = byp_out_r;
   assign charz_enable      = chz_en_r;
   assign charz_direction   = chz_dir_r;
   assign charz_lane_onehot = chz_oh_r;
   assign irq               = irq_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_ralg_rise;
      ralg_r[0][0] && !$past(ralg_r[0][0]);
   endsequence
   sequence s_one_pulse(sig);
      sig ##1 !sig;
   endsequence

   property p_realign;
      @(posedge pclk) disable iff (!presetn)
      s_ralg_rise |=> s_one_pulse(lane_ctrl_r[0].realign);
   endproperty
   a_realign: assert property (p_realign) else $error("realign pulse missing");

   property p_participate;
      @(posedge pclk) disable iff (!presetn)
      ##1 lane_ctrl_r[5].participate == $past(ralg_r[1][5]);
   endproperty
   a_participate: assert property (p_participate) else $error("participate wrong");

   property p_group;
      @(posedge pclk) disable iff (!presetn)
      $past(grp_r[0][5:4]) == 2'b10 |-> lane_ctrl_r[2].group == LARC_GRP_FOUR;
   endproperty
   a_group: assert property (p_group) else $error("group code wrong");

   property p_pair;
      @(posedge pclk) disable iff (!presetn)
      (rsyn_r[0][5] && !rsyn_prev_r[0][5]) |=> lane_ctrl_r[2].ptr_reset
                                              && lane_ctrl_r[3].ptr_reset;
   endproperty
   a_pair: assert property (p_pair) else $error("pair resync missed");

   property p_no_retrigger;
      @(posedge pclk) disable iff (!presetn)
      lane_ctrl_r[4].ptr_reset && rsyn_r[1] == $past(rsyn_r[1]) |=> !lane_ctrl_r[4].ptr_reset;
   endproperty
   a_no_retrigger: assert property (p_no_retrigger) else $error("resync retriggered");

   property p_quad_sel;
      @(posedge pclk) disable iff (!presetn)
      rsyn_r[0][LARC_XSEL_BIT] [*2] |-> lane_ctrl_r[1].use_xaui;
   endproperty
   a_quad_sel: assert property (p_quad_sel) else $error("quad select ignored");

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      byp_r[1] |=> deskew_bypass[1];
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not applied");

   property p_charz;
      @(posedge pclk) disable iff (!presetn)
      chz_r[1:0] == 2'b01 |=> charz_lane_onehot == 4'h2;
   endproperty
   a_charz: assert property (p_charz) else $error("charz lane wrong");

   property p_sync_done;
      @(posedge pclk) disable iff (!presetn)
      stat_sync_r[0][5] |=> link_stat_r[5] == LARC_LS_DONE;
   endproperty
   a_sync_done: assert property (p_sync_done) else $error("sync done not shown");

   property p_oos;
      @(posedge pclk) disable iff (!presetn)
      $rose(oos_sync_r[0]) |=> irq_stat_r[LARC_IRQ_OOS_LSB] [*2];
   endproperty
   a_oos: assert property (p_oos) else $error("out of sync flag lost");

endmodule
